// ===== hdl/dqt_pkg.sv
// Constants, codes and register map of the DQ training block
// ============================================================
// Summary of operation
// - Calibration burst sends first pattern byte then second on all DQ and DMI lanes
// - Each pattern byte goes out least significant bit first
// - DQ lanes with mask bit set are inverted; DMI lanes never inverted
// - DMI floats only when mask, write DBI and read DBI are all off
// - No bus inversion is applied to calibration data
// - Calibration data follows ordinary read latency
// - Calibration commands spaced one burst apart give gapless bursts
// - Training reads use sixteen beats, toggling preamble and short postamble
// - MPC with operand bit 6 low is ignored; else bits 5-0 pick function
// - FIFO write takes data after write latency counted from CAS-2
// - FIFO holds five bursts of sixteen bits per pin
// - FIFO read returns data after read latency counted from CAS-2
// - FIFO reads keep contents; listed commands and clock-enable low disturb it
// - Never-written entries read back as defined logic levels
// - FIFO reads step through entries zero to four then wrap
// - Write pointer resets at power-up, reset, and power-down entry
// - Ordinary read advances both FIFO pointers by one
// - Sixth FIFO write overwrites the first entry
// - Pattern bytes default 5A and 3C, invert masks default 55
package dqt_pkg;
  // ============================================================
  // Geometry
  localparam int BURST_LEN  = 16;
  localparam int DQ_W       = 16;
  localparam int LANES      = 18;
  localparam int FIFO_DEPTH = 5;
  localparam int MAX_LAT    = 32;
  localparam logic [4:0] LAT_MIN = 5'h03;
  // ============================================================
  // Register offsets and reset values
  localparam logic [7:0] OFS_PAT_FIRST  = 8'h00;
  localparam logic [7:0] OFS_PAT_SECOND = 8'h04;
  localparam logic [7:0] OFS_INV_LOW    = 8'h08;
  localparam logic [7:0] OFS_INV_HIGH   = 8'h0C;
  localparam logic [7:0] OFS_MODE       = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;
  localparam logic [7:0] OFS_CONTROL    = 8'h18;
  localparam logic [7:0] PAT_FIRST_RST  = 8'h5A;
  localparam logic [7:0] PAT_SECOND_RST = 8'h3C;
  localparam logic [7:0] INV_RST        = 8'h55;
  localparam logic [4:0] RL_RST         = 5'h0E;
  localparam logic [4:0] WL_RST         = 5'h08;
  // Field positions in the mode register
  localparam int MODE_DM_BIT   = 0;
  localparam int MODE_WDBI_BIT = 1;
  localparam int MODE_RDBI_BIT = 2;
  localparam int MODE_RL_LSB   = 8;
  localparam int MODE_WL_LSB   = 16;
  // ============================================================
  // Command bus codes and training functions
  localparam logic [2:0] CMD_DES  = 3'h0;
  localparam logic [2:0] CMD_MPC  = 3'h1;
  localparam logic [2:0] CMD_CAS2 = 3'h2;
  localparam logic [2:0] CMD_RD   = 3'h3;
  localparam logic [2:0] CMD_WR   = 3'h4;
  localparam logic [2:0] CMD_MWR  = 3'h5;
  localparam logic [2:0] CMD_MRR  = 3'h6;
  localparam int MPC_TRAIN_BIT = 6;
  localparam logic [5:0] FN_RD_FIFO = 6'h01;
  localparam logic [5:0] FN_WR_FIFO = 6'h02;
  localparam logic [5:0] FN_RD_CAL  = 6'h03;
  localparam logic [1:0] KIND_NONE = 2'h0;
  localparam logic [1:0] KIND_CAL  = 2'h1;
  localparam logic [1:0] KIND_RDF  = 2'h2;
  localparam logic [1:0] KIND_WRF  = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {DQT_IDLE, DQT_WAIT_CAS} dqt_state_e;
endpackage : dqt_pkg

// ===== hdl/dqt_serializer.sv
// Per-lane burst serialiser for training read data
`timescale 1ns/1ps
module dqt_serializer
  import dqt_pkg::*;
#(
  parameter int LN = LANES,
  parameter int BL = BURST_LEN
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [LN*BL-1:0] words,
  output logic      [LN-1:0]    bits,
  output logic                  active,
  output logic                  phase,
  output logic                  last
);
  localparam int BW = $clog2(BL);
  localparam logic [BW-1:0] LAST_BEAT = BW'(BL - 1);

  logic [BL-1:0] sr [LN];
  logic [BW-1:0] beat;

  assign last = active && (beat == LAST_BEAT);

  // ============================================================
  // Lane shift registers, low bit leaves first
  genvar g;
  generate
    for (g = 0; g < LN; g++) begin : g_lane
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sr[g] <= '0;
        end else if (load) begin
          sr[g] <= words[g*BL +: BL];
        end else begin
          sr[g] <= {1'b0, sr[g][BL-1:1]};
        end
      end
      assign bits[g] = sr[g][0];
    end
  endgenerate

  // Beat counter; a load on the last beat continues without a gap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      beat   <= '0;
      active <= 1'b0;
      phase  <= 1'b0;
    end else if (load) begin
      beat   <= '0;
      active <= 1'b1;
      phase  <= 1'b1;
    end else if (active) begin
      beat   <= beat + 1'b1;
      active <= !last;
      phase  <= !phase;
    end
  end
endmodule : dqt_serializer

// ===== hdl/dqt_top.sv
// DQ training logic: calibration pattern, training FIFO, register slave
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module dqt_top
  import dqt_pkg::*;
#(
  parameter int LAT_DEPTH = MAX_LAT
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        CKE,
  input  wire logic [2:0]  CA_CMD,
  input  wire logic [6:0]  CA_OP,
  input  wire logic [15:0] DQ_IN,
  output logic [15:0]      DQ_OUT,
  output logic             DQ_OE,
  input  wire logic [1:0]  DMI_IN,
  output logic [1:0]       DMI_OUT,
  output logic             DMI_OE,
  output logic             DQS_OUT,
  output logic             DQS_OE
);
  localparam int WW = LANES * BURST_LEN;

  // ============================================================
  // Software-visible state
  logic [7:0] pat_first;
  logic [7:0] pat_second;
  logic [7:0] inv_low;
  logic [7:0] inv_high;
  logic       dm_en;
  logic       wdbi_en;
  logic       rdbi_en;
  logic [4:0] rl;
  logic [4:0] wl;
  logic       disturbed;

  // Bus slave state
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // Command and datapath state
  dqt_state_e state;
  dqt_state_e next_state;
  logic [1:0] pend_kind;
  logic [1:0] dly [LAT_DEPTH];
  logic       cke_q;
  logic       post_q;
  logic       cap_active;
  logic [3:0] cap_cnt;
  logic [BURST_LEN-1:0] cap [LANES];

  // Serialiser and FIFO wires
  logic [LANES-1:0] ser_bits;
  logic             ser_active;
  logic             ser_phase;
  logic             ser_last;
  logic [WW-1:0]    fifo_rdata;
  logic [WW-1:0]    cal_words;
  logic [WW-1:0]    cap_words;
  logic [2:0]       wr_ptr;
  logic [2:0]       rd_ptr;

  // ============================================================
  // Register read value, shared by the read path and the merge on write
  function automatic logic [31:0] reg_value(input logic [7:0] a);
    unique case (a)
      OFS_PAT_FIRST:  reg_value = {24'h000000, pat_first};
      OFS_PAT_SECOND: reg_value = {24'h000000, pat_second};
      OFS_INV_LOW:    reg_value = {24'h000000, inv_low};
      OFS_INV_HIGH:   reg_value = {24'h000000, inv_high};
      OFS_MODE:       reg_value = {11'h000, wl, 3'h0, rl, 5'h00, rdbi_en, wdbi_en, dm_en};
      OFS_STATUS:     reg_value = {21'h000000, disturbed, cap_active, ser_active,
                                   1'b0, rd_ptr, 1'b0, wr_ptr};
      default:        reg_value = 32'h00000000;
    endcase
  endfunction : reg_value

  // Address is mapped
  // Every aligned word from the first pattern byte up to control is a register
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a <= OFS_CONTROL) && (a[1:0] == 2'b00);
  endfunction : reg_hit

  // ============================================================
  // Write channel handshakes and byte-lane merge
  wire        aw_fire  = S_AXI_AWVALID && S_AXI_AWREADY;
  wire        w_fire   = S_AXI_WVALID && S_AXI_WREADY;
  wire        do_write = aw_held && w_held && !S_AXI_BVALID;
  wire [31:0] strb_m   = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] merged   = (reg_value(aw_addr) & ~strb_m) | (w_data & strb_m);
  wire        wr_ok    = do_write && reg_hit(aw_addr);
  wire        clr_dist = wr_ok && (aw_addr == OFS_CONTROL) && w_strb[0] && w_data[0];

  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  // Address and data may arrive in either order
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_fire) aw_addr <= S_AXI_AWADDR;
      if (w_fire) w_data <= S_AXI_WDATA;
      if (w_fire) w_strb <= S_AXI_WSTRB;
      aw_held <= do_write ? 1'b0 : (aw_held || aw_fire);
      w_held  <= do_write ? 1'b0 : (w_held || w_fire);
    end
  end

  // Write response, error on unmapped address
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= reg_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Read response one cycle after the address is taken
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h00000000;
      S_AXI_RRESP  <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= reg_value(S_AXI_ARADDR);
      S_AXI_RRESP  <= reg_hit(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ============================================================
  // Pattern, mask and mode registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pat_first  <= PAT_FIRST_RST;
      pat_second <= PAT_SECOND_RST;
      inv_low    <= INV_RST;
      inv_high   <= INV_RST;
      dm_en      <= 1'b0;
      wdbi_en    <= 1'b0;
      rdbi_en    <= 1'b0;
      rl         <= RL_RST;
      wl         <= WL_RST;
    end else if (wr_ok) begin
      if (aw_addr == OFS_PAT_FIRST) pat_first <= merged[7:0];
      if (aw_addr == OFS_PAT_SECOND) pat_second <= merged[7:0];
      if (aw_addr == OFS_INV_LOW) inv_low <= merged[7:0];
      if (aw_addr == OFS_INV_HIGH) inv_high <= merged[7:0];
      if (aw_addr == OFS_MODE) begin
        dm_en   <= merged[MODE_DM_BIT];
        wdbi_en <= merged[MODE_WDBI_BIT];
        rdbi_en <= merged[MODE_RDBI_BIT];
        rl      <= merged[MODE_RL_LSB +: 5];
        wl      <= merged[MODE_WL_LSB +: 5];
      end
    end
  end

  // ============================================================
  // Command decode; clock enable low shuts the command inputs
  wire [2:0] cmd      = CKE ? CA_CMD : CMD_DES;
  wire       mpc_t    = (cmd == CMD_MPC) && CA_OP[MPC_TRAIN_BIT];
  wire [1:0] mpc_kind = !mpc_t ? KIND_NONE :
                        (CA_OP[5:0] == FN_RD_CAL)  ? KIND_CAL :
                        (CA_OP[5:0] == FN_RD_FIFO) ? KIND_RDF :
                        (CA_OP[5:0] == FN_WR_FIFO) ? KIND_WRF : KIND_NONE;
  wire       cas_go   = (state == DQT_WAIT_CAS) && (cmd == CMD_CAS2);
  wire [1:0] launch   = cas_go ? pend_kind : KIND_NONE;
  wire       pd_entry = cke_q && !CKE;
  wire       rd_cmd   = (cmd == CMD_RD);
  wire       disturb  = rd_cmd || (cmd == CMD_WR) || (cmd == CMD_MWR) ||
                        (cmd == CMD_MRR) || (launch == KIND_CAL) || pd_entry;

  // A training MPC waits only one slot for its CAS-2
  assign next_state = (mpc_kind != KIND_NONE) ? DQT_WAIT_CAS : DQT_IDLE;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state     <= DQT_IDLE;
      pend_kind <= KIND_NONE;
      cke_q     <= 1'b0;
    end else begin
      state     <= next_state;
      pend_kind <= mpc_kind;
      cke_q     <= CKE;
    end
  end

  // FIFO disturbance flag; a new event beats a software clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      disturbed <= 1'b0;
    end else if (disturb) begin
      disturbed <= 1'b1;
    end else if (clr_dist || (launch == KIND_WRF)) begin
      disturbed <= 1'b0;
    end
  end

  // ============================================================
  // Latency line: entry k holds a launch taken k+1 edges ago
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < LAT_DEPTH; i++) dly[i] <= KIND_NONE;
    end else begin
      dly[0] <= launch;
      for (int i = 1; i < LAT_DEPTH; i++) dly[i] <= dly[i-1];
    end
  end

  wire [4:0] rl_eff  = (rl < LAT_MIN) ? LAT_MIN : rl;
  wire [4:0] wl_eff  = (wl < LAT_MIN) ? LAT_MIN : wl;
  wire [1:0] tap_rd  = dly[rl_eff - 5'h01];
  wire [1:0] tap_pre = dly[rl_eff - 5'h02];
  wire [1:0] tap_wr  = dly[wl_eff];
  wire       ser_ld  = (tap_rd == KIND_CAL) || (tap_rd == KIND_RDF);
  wire       pre_far = (tap_pre == KIND_CAL) || (tap_pre == KIND_RDF);
  wire       fifo_rd = (tap_rd == KIND_RDF);

  // ============================================================
  // Calibration words: first byte in beats 0-7, second in 8-15
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_cal
      if (g < DQ_W) begin : g_dq
        wire inv = (g < 8) ? inv_low[g % 8] : inv_high[g % 8];
        assign cal_words[g*BURST_LEN +: BURST_LEN] =
          {pat_second, pat_first} ^ {BURST_LEN{inv}};
        assign cap_words[g*BURST_LEN +: BURST_LEN] = {DQ_IN[g], cap[g][BURST_LEN-1:1]};
      end else begin : g_dmi
        assign cal_words[g*BURST_LEN +: BURST_LEN] = {pat_second, pat_first};
        assign cap_words[g*BURST_LEN +: BURST_LEN] = {DMI_IN[g - DQ_W], cap[g][BURST_LEN-1:1]};
      end
    end
  endgenerate

  // Serialiser; a load on the last beat chains bursts without a gap
  dqt_serializer #(
    .LN (LANES),
    .BL (BURST_LEN)
  ) u_ser (
    .clk    (CLK),
    .rst_n  (RST_N),
    .load   (ser_ld),
    .words  (fifo_rd ? fifo_rdata : cal_words),
    .bits   (ser_bits),
    .active (ser_active),
    .phase  (ser_phase),
    .last   (ser_last)
  );

  // ============================================================
  // Write capture: sixteen beats per lane, stored on the last one
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cap_active <= 1'b0;
      cap_cnt    <= 4'h0;
    end else if (tap_wr == KIND_WRF) begin
      cap_active <= 1'b1;
      cap_cnt    <= 4'h0;
    end else if (cap_active) begin
      cap_cnt    <= cap_cnt + 4'h1;
      cap_active <= (cap_cnt != 4'hF);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < LANES; i++) cap[i] <= '0;
    end else if (cap_active) begin
      for (int i = 0; i < LANES; i++) cap[i] <= cap_words[i*BURST_LEN +: BURST_LEN];
    end
  end

  dqt_train_fifo #(
    .W     (WW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (CLK),
    .rst_n    (RST_N),
    .clr      (pd_entry),
    .store    (cap_active && (cap_cnt == 4'hF)),
    .wdata    (cap_words),
    .rd_adv   (fifo_rd),
    .both_adv (rd_cmd),
    .rdata    (fifo_rdata),
    .wr_ptr   (wr_ptr),
    .rd_ptr   (rd_ptr)
  );

  // ============================================================
  // Strobe: two-beat toggling preamble, one low beat after the burst
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      post_q <= 1'b0;
    end else begin
      post_q <= ser_last && !ser_ld;
    end
  end

  assign DQ_OUT  = ser_bits[DQ_W-1:0];
  assign DQ_OE   = ser_active;
  assign DMI_OUT = ser_bits[LANES-1:DQ_W];
  assign DMI_OE  = ser_active && (dm_en || wdbi_en || rdbi_en);
  assign DQS_OE  = ser_active || ser_ld || pre_far || post_q;
  assign DQS_OUT = ser_active ? ser_phase : (!ser_ld && pre_far);
endmodule : dqt_top

// ===== hdl/dqt_train_fifo.sv
// Five-entry training FIFO with wrapping pointers
`timescale 1ns/1ps
module dqt_train_fifo
  import dqt_pkg::*;
#(
  parameter int W     = LANES * BURST_LEN,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     clr,
  input  wire logic                     store,
  input  wire logic [W-1:0]             wdata,
  input  wire logic                     rd_adv,
  input  wire logic                     both_adv,
  output logic      [W-1:0]             rdata,
  output logic      [$clog2(DEPTH)-1:0] wr_ptr,
  output logic      [$clog2(DEPTH)-1:0] rd_ptr
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];

  // Next pointer with wrap after the last entry
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  // ============================================================
  // Storage; cleared at reset so unwritten entries read defined levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
    end else if (store) begin
      mem[wr_ptr] <= wdata;
    end
  end

  // Pointers; clear wins over any advance
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (clr) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (store || both_adv) wr_ptr <= bump(wr_ptr);
      if (rd_adv || both_adv) rd_ptr <= bump(rd_ptr);
    end
  end

  assign rdata = mem[rd_ptr];
endmodule : dqt_train_fifo

// ===== tb/dqt_ctrl_model.sv
// Memory controller model
`timescale 1ns/1ps
module dqt_ctrl_model
  import dqt_pkg::*;
(
  input  wire logic        CLK,
  output logic             CKE,
  output logic [2:0]       CA_CMD,
  output logic [6:0]       CA_OP,
  output logic [15:0]      DQ_IN,
  output logic [1:0]       DMI_IN,
  input  wire logic [15:0] DQ_OUT,
  input  wire logic        DQ_OE,
  input  wire logic [1:0]  DMI_OUT,
  input  wire logic        DMI_OE
);
  logic [19:0] cap [17];
  // ============================================================
  // Idle bus at time zero
  initial begin
    {CKE, CA_CMD, CA_OP, DMI_IN, DQ_IN} = {1'b1, CMD_DES, 25'h0};
  end
  // Beat pattern of write burst k
  function automatic logic [17:0] wbeat(input int k, input int i);
    return {i[1:0] ^ k[1:0], k[3:0], i[3:0], ~k[3:0], ~i[3:0]};
  endfunction : wbeat
  // Training MPC then CAS-2
  task issue(input logic [6:0] op);
    @(posedge CLK);
    CA_CMD <= CMD_MPC;
    CA_OP <= op;
    @(posedge CLK);
    CA_CMD <= CMD_CAS2;
    CA_OP <= 7'h00;
    @(posedge CLK);
    CA_CMD <= CMD_DES;
  endtask : issue
  // One plain command
  task single(input logic [2:0] c);
    @(posedge CLK);
    CA_CMD <= c;
    @(posedge CLK);
    CA_CMD <= CMD_DES;
  endtask : single
  // Clock enable level
  task power(input logic v);
    @(posedge CLK);
    CKE <= v;
  endtask : power
  // Write burst after write latency
  task push(input int wl, input int k);
    repeat (wl + 1) @(posedge CLK);
    for (int i = 0; i < 16; i++) begin
      {DMI_IN, DQ_IN} <= wbeat(k, i);
      @(posedge CLK);
    end
    {DMI_IN, DQ_IN} <= ~{DMI_IN, DQ_IN};
  endtask : push
  // Capture one idle beat then sixteen burst beats
  task grab(input int rl);
    repeat (rl - 1) @(posedge CLK);
    for (int i = 0; i < 17; i++) begin
      @(negedge CLK);
      cap[i] = {DMI_OE, DQ_OE, DMI_OUT, DQ_OUT};
    end
  endtask : grab
endmodule : dqt_ctrl_model

// ===== tb/dqt_properties.sv
// Port checks for the DQ training block
`timescale 1ns/1ps
module dqt_properties
  import dqt_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        DQ_OE,
  input wire logic        DMI_OE,
  input wire logic        DQS_OUT,
  input wire logic        DQS_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ============================================================
  // Burst framing, strobe and register answers
  property p_len; $rose(DQ_OE) |-> DQ_OE[*8] ##1 DQ_OE[*8]; endproperty
  a_len: assert property (p_len) else $error("short burst");
  property p_pre; $rose(DQ_OE) |-> $past(DQS_OE, 2) && $past(DQS_OE) && $past(DQS_OUT, 2) && !$past(DQS_OUT); endproperty
  a_pre: assert property (p_pre) else $error("no preamble");
  property p_first; $rose(DQ_OE) |-> DQS_OUT; endproperty
  a_first: assert property (p_first) else $error("bad first strobe");
  property p_tog; DQ_OE && $past(DQ_OE) |-> DQS_OUT != $past(DQS_OUT); endproperty
  a_tog: assert property (p_tog) else $error("no toggle");
  property p_post; $fell(DQ_OE) |-> DQS_OE && !DQS_OUT ##1 !DQS_OE; endproperty
  a_post: assert property (p_post) else $error("bad postamble");
  property p_dmi; DMI_OE |-> DQ_OE; endproperty
  a_dmi: assert property (p_dmi) else $error("stray mask drive");
  property p_dqs; DQ_OE |-> DQS_OE; endproperty
  a_dqs: assert property (p_dqs) else $error("strobe off");
  property p_arrdy; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
  a_arrdy: assert property (p_arrdy) else $error("early read address");
  property p_unmap; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h18
    |=> S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
endmodule : dqt_properties

// ===== tb/tb_dqt_top.sv
// Testbench for the DQ training block
`timescale 1ns/1ps
module tb_dqt_top
  import dqt_pkg::*;
;
  typedef struct packed {logic [7:0] p1, p2, il, ih; logic [2:0] md; logic [4:0] rl; logic doe;} dqt_row_s;
  localparam dqt_row_s ROWS [8] = '{
    '{8'h1C, 8'h59, 8'h55, 8'h55, 3'h0, 5'h0E, 1'h0}, '{8'h27, 8'hD8, 8'hFF, 8'h00, 3'h1, 5'h03, 1'h1},
    '{8'h00, 8'hFF, 8'h0F, 8'hF0, 3'h2, 5'h07, 1'h1}, '{8'hA5, 8'h5A, 8'h81, 8'h18, 3'h3, 5'h0E, 1'h1},
    '{8'h01, 8'h80, 8'h00, 8'hFF, 3'h4, 5'h1F, 1'h1}, '{8'hF0, 8'h0F, 8'hAA, 8'h55, 3'h5, 5'h02, 1'h1},
    '{8'h3C, 8'hC3, 8'h12, 8'h34, 3'h6, 5'h09, 1'h1}, '{8'hFF, 8'h00, 8'hFF, 8'hFF, 3'h7, 5'h0E, 1'h1}};
  localparam logic [19:0] DEF [5] = '{20'h0005A, 20'h0003C, 20'h00055, 20'h00055, 20'h80E00};
  logic CLK = '0, RST_N = '0, S_AXI_AWVALID = '0, S_AXI_WVALID = '0, S_AXI_BREADY = '0;
  logic S_AXI_ARVALID = '0, S_AXI_RREADY = '0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, CKE, DQ_OE, DMI_OE, DQS_OUT, DQS_OE;
  logic [7:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
  logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, DMI_IN, DMI_OUT;
  logic [2:0] CA_CMD;
  logic [6:0] CA_OP;
  logic [15:0] DQ_IN, DQ_OUT;
  int failures = 0;
  int tests_run = 0;
  // ============================================================
  // Design, controller model and clock
  dqt_top dqt_top_i (.*);
  dqt_ctrl_model dqt_ctrl_model_i (.*);
  always #20 CLK = ~CLK;
  // Compare and count
  task chk(input logic [19:0] got, input logic [19:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("FAIL at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Register write
  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask : axw
  // Register read
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask : axr
  // Calibration burst check
  task cal_chk(input logic [7:0] p1, p2, il, ih, input logic doe, input int rl);
    logic [15:0] w;
    logic [19:0] m;
    w = {p2, p1};
    m = doe ? 20'hFFFFF : 20'hCFFFF;
    dqt_ctrl_model_i.issue(7'h43);
    dqt_ctrl_model_i.grab(rl < 3 ? 3 : rl);
    chk(dqt_ctrl_model_i.cap[0][18], 1'b0);
    for (int i = 0; i < 16; i++) begin
      chk(dqt_ctrl_model_i.cap[i + 1] & m, {doe, 1'b1, {2{w[i]}}, {16{w[i]}} ^ {ih, il}} & m);
    end
  endtask : cal_chk
  // Verdict
  task stop_test;
    $display("Counts: %0d checks, %0d mismatches", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // Watchdog
  initial begin
    repeat (8000) @(posedge CLK);
    failures++;
    stop_test;
  end
  // Main sequence
  initial begin
    dqt_row_s row;
    logic [31:0] rd;
    logic [1:0] rs;
    int hit;
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    for (int r = 0; r < 8; r++) begin
      row = ROWS[r];
      axw(OFS_PAT_FIRST, {24'h0, row.p1}, rs);
      axw(OFS_PAT_SECOND, {24'h0, row.p2}, rs);
      axw(OFS_INV_LOW, {24'h0, row.il}, rs);
      axw(OFS_INV_HIGH, {24'h0, row.ih}, rs);
      axw(OFS_MODE, {11'h0, WL_RST, 3'h0, row.rl, 5'h0, row.md}, rs);
      cal_chk(row.p1, row.p2, row.il, row.ih, row.doe, row.rl);
      $display("Row %0d done", r);
    end
    axw(OFS_MODE, {11'h0, WL_RST, 3'h0, RL_RST, 5'h0, 3'h1}, rs);
    for (int k = 0; k < 6; k++) begin
      dqt_ctrl_model_i.issue(7'h42);
      dqt_ctrl_model_i.push(WL_RST, k);
    end
    for (int k = 0; k < 6; k++) begin
      dqt_ctrl_model_i.issue(7'h41);
      dqt_ctrl_model_i.grab(RL_RST);
      chk(dqt_ctrl_model_i.cap[0][18], 1'b0);
      for (int i = 0; i < 16; i++) begin
        chk(dqt_ctrl_model_i.cap[i + 1], {2'h3, dqt_ctrl_model_i.wbeat(k % 5 == 0 ? 5 : k, i)});
      end
    end
    dqt_ctrl_model_i.single(CMD_RD);
    axr(OFS_STATUS, rd, rs);
    chk(rd[19:0] & 20'h00477, 20'h00422);
    dqt_ctrl_model_i.power(1'b0);
    dqt_ctrl_model_i.power(1'b1);
    axr(OFS_STATUS, rd, rs);
    chk(rd[19:0] & 20'h00077, 20'h00000);
    $display("Training store test done");
    hit = 0;
    dqt_ctrl_model_i.issue(7'h03);
    dqt_ctrl_model_i.issue(7'h7F);
    repeat (40) begin
      @(negedge CLK);
      hit += DQ_OE;
    end
    chk(hit[19:0], 20'h0);
    hit = 0;
    dqt_ctrl_model_i.issue(7'h43);
    repeat (13) @(posedge CLK);
    dqt_ctrl_model_i.issue(7'h43);
    repeat (31) begin
      @(negedge CLK);
      hit += DQ_OE;
    end
    chk(hit[19:0], 20'h1E);
    axr(8'h1C, rd, rs);
    chk({rs, rd[17:0]}, {RESP_SLVERR, 18'h0});
    axw(8'h1C, 32'h0000_00FF, rs);
    chk({18'h0, rs}, {18'h0, RESP_SLVERR});
    $display("Command and address test done");
    RST_N <= 1'b0;
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    for (int j = 0; j < 5; j++) begin
      axr(8'(4 * j), rd, rs);
      chk(rd[19:0], DEF[j]);
    end
    cal_chk(PAT_FIRST_RST, PAT_SECOND_RST, INV_RST, INV_RST, 1'b0, RL_RST);
    dqt_ctrl_model_i.issue(7'h41);
    dqt_ctrl_model_i.grab(RL_RST);
    chk(dqt_ctrl_model_i.cap[1], 20'h40000);
    S_AXI_WSTRB <= 4'h2;
    axw(OFS_PAT_FIRST, 32'h0000_00FF, rs);
    axr(OFS_PAT_FIRST, rd, rs);
    chk(rd[19:0], {12'h0, PAT_FIRST_RST});
    $display("Reset test done");
    stop_test;
  end
endmodule : tb_dqt_top
bind dqt_top dqt_properties dqt_properties_i (.*);
